/* File: hdl/ccdd_defines.svh */
`ifndef CCDD_DEFINES_SVH
`define CCDD_DEFINES_SVH

// Record layout, byte offsets within the descriptor EEPROM
`define CCDD_SIG0 8'hAA
`define CCDD_SIG1 8'h55
`define CCDD_SIG2 8'h33
`define CCDD_SIG3 8'hEE
`define CCDD_SIG_LEN 8'h04
`define CCDD_OFS_PART 8'h3A
`define CCDD_PART_LEN 8'h10
`define CCDD_OFS_PINCNT 8'h4A
`define CCDD_PINCNT_MAX 16'h005C
`define CCDD_OFS_SERIAL 8'h4C
`define CCDD_SERIAL_LEN 8'h0C
`define CCDD_OFS_SEQ 8'h54
`define CCDD_OFS_PINS 8'h58
`define CCDD_PIN_BYTES 8'h94
`define CCDD_NUM_PINS 7'h4A
`define CCDD_OFS_AUX33 8'hEC
`define CCDD_OFS_IN5 8'hEE
`define CCDD_OFS_SYS5 8'hF0
`define CCDD_OFS_SUPPLY 8'hF2
`define CCDD_OFS_LAST 8'hF3
`define CCDD_FREE_BASE 16'h00F4
`define CCDD_FREE_LEN 16'h7F1F
`define CCDD_EE_ADDR_LO 7'h54
`define CCDD_EE_ADDR_HI 7'h57

// Pin configuration word fields
`define CCDD_PW_USED 15
`define CCDD_PW_RES_HI 14
`define CCDD_PW_RES_LO 7
`define CCDD_PW_SLOW 6
`define CCDD_PW_RXEN 5
`define CCDD_PW_PULLUP 4
`define CCDD_PW_PULLDIS 3
`define CCDD_PW_MUX_HI 2

// APB register byte addresses
`define CCDD_REG_CTRL 12'h000
`define CCDD_REG_STATUS 12'h004
`define CCDD_REG_IRQ_STATUS 12'h008
`define CCDD_REG_IRQ_MASK 12'h00C
`define CCDD_REG_PINCNT 12'h010
`define CCDD_REG_AUX33 12'h014
`define CCDD_REG_IN5 12'h018
`define CCDD_REG_SYS5 12'h01C
`define CCDD_REG_SUPPLY 12'h020
`define CCDD_REG_SERIAL0 12'h024
`define CCDD_REG_SERIAL2 12'h02C
`define CCDD_REG_SEQ 12'h030
`define CCDD_REG_DATE 12'h034
`define CCDD_REG_PART0 12'h040
`define CCDD_REG_PART3 12'h04C
`define CCDD_REG_PIN0 12'h100
`define CCDD_REG_PINL 12'h224

`endif

/* File: hdl/ccdd_pkg.sv */
package ccdd_pkg;
  typedef enum logic [1:0] {
    CCDD_IDLE = 2'b01,
    CCDD_FETCH = 2'b10
  } ccdd_state_t;
endpackage : ccdd_pkg

/* File: hdl/ccdd_decoder.sv */
// Operation
// - A record is accepted only if its first four bytes are the fixed signature; otherwise the board is invalid.
// - Each EEPROM location at offsets 0 to 3 and 58 to 243 is fetched as one byte using a two-byte memory address.
// - Descriptor EEPROMs are probed only at bus addresses 0x54 to 0x57, one per board slot.
// - The sixteen bytes from offset 58 are kept as the ASCII part number.
// - The two bytes at offset 74 are the binary used-pin count, legal up to 92.
// - Offset 76 holds the 12-character serial: week, year, assembly code, sequence.
// - The last four serial characters are decoded as the board count within that week.
// - From offset 88, 148 bytes are read as 74 two-byte pin words in fixed order.
// - Each pin word is handed on as that pin's pad-control value, unchanged except on analog pins.
// - Every sixteen-bit value is assembled big-endian, first byte most significant.
// - Bit 15 of a pin word marks the pin as used by the board.
// - Pin word bits are mux mode, pull disable, pull-up, receiver enable, slow slew and reserved 14 to 7.
// - For analog input pins only bit 15 is honoured and the other bits are dropped.
// - Offsets 236, 238 and 240 give the current limits of the aux 3.3 V, input 5 V and system 5 V rails.
// - Offset 242 is zero when the board feeds nothing onto the input 5 V rail, else the current it supplies.
// - Offsets from 244 onward are free data and never decoded.
`timescale 1ns/10ps
`include "ccdd_defines.svh"

module ccdd_decoder #(
  parameter logic [6:0] ANALOG_FIRST = 7'h43,
  parameter logic [6:0] ANALOG_COUNT = 7'h07
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fetch_req,
  output logic [6:0] fetch_dev_addr,
  output logic [15:0] fetch_mem_addr,
  input wire logic fetch_ack,
  input wire logic fetch_nack,
  input wire logic [7:0] fetch_data,
  output logic pad_valid,
  output logic [6:0] pad_index,
  output logic [15:0] pad_word,
  output logic irq
);

  localparam int REC_LEN = 186;

  ccdd_pkg::ccdd_state_t state, next_state;
  logic [7:0] rec [0:REC_LEN-1];
  logic [7:0] ofs, next_ofs;
  logic [1:0] slot, next_slot;
  logic [3:0] present, next_present;
  logic done, next_done;
  logic valid, next_valid;
  logic sig_err, next_sig_err;
  logic cnt_err, next_cnt_err;
  logic res_err, next_res_err;
  logic nack_err, next_nack_err;
  logic [1:0] irq_st, next_irq_st;
  logic [1:0] irq_mask, next_irq_mask;
  logic next_irq;
  logic next_fetch_req;
  logic [6:0] next_fetch_dev_addr;
  logic next_pad_valid;
  logic [6:0] next_pad_index;
  logic [15:0] next_pad_word;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic rec_we;
  logic [7:0] rec_idx;
  logic [7:0] sig_byte;
  logic [15:0] word;
  logic [6:0] pin;
  logic analog;
  logic wr_acc, start, ev_done, ev_err;

  function automatic logic [15:0] be16(input logic [7:0] o);
    be16 = {rec[o - `CCDD_OFS_PART], rec[o - `CCDD_OFS_PART + 8'h01]};
  endfunction : be16

  function automatic logic [13:0] dig(input logic [7:0] c);
    dig = {10'h000, c[3:0]};
  endfunction : dig

  function automatic logic is_analog(input logic [6:0] p);
    is_analog = (p >= ANALOG_FIRST) && (p < ANALOG_FIRST + ANALOG_COUNT);
  endfunction : is_analog

  // Analog pins expose only the use bit
  function automatic logic [15:0] honour(input logic [6:0] p, input logic [15:0] w);
    honour = is_analog(p) ? {w[`CCDD_PW_USED], 15'h0000} : w;
  endfunction : honour

  always_comb
  begin
    case (ofs[1:0])
      2'h0: sig_byte = `CCDD_SIG0;
      2'h1: sig_byte = `CCDD_SIG1;
      2'h2: sig_byte = `CCDD_SIG2;
      default: sig_byte = `CCDD_SIG3;
    endcase
    wr_acc = psel && penable && pready && pwrite;
    start = wr_acc && (paddr == `CCDD_REG_CTRL) && pwdata[0];
    rec_idx = ofs - `CCDD_OFS_PART;
    rec_we = (state == ccdd_pkg::CCDD_FETCH) && fetch_ack && !fetch_nack && (ofs >= `CCDD_OFS_PART);
    word = {rec[rec_idx - 8'h01], fetch_data};
    pin = 7'((ofs - `CCDD_OFS_PINS) >> 1);
    analog = is_analog(pin);
    next_state = state;
    next_ofs = ofs;
    next_slot = slot;
    next_present = present;
    next_done = done;
    next_valid = valid;
    next_sig_err = sig_err;
    next_cnt_err = cnt_err;
    next_res_err = res_err;
    next_nack_err = nack_err;
    next_fetch_req = fetch_req;
    next_fetch_dev_addr = fetch_dev_addr;
    next_pad_valid = 1'b0;
    next_pad_index = pad_index;
    next_pad_word = pad_word;
    ev_done = 1'b0;
    ev_err = 1'b0;
    case (state)
      ccdd_pkg::CCDD_IDLE:
      begin
        if (start)
        begin
          next_slot = pwdata[2:1];
          next_fetch_dev_addr = `CCDD_EE_ADDR_LO + {5'h00, pwdata[2:1]};
          next_ofs = 8'h00;
          next_fetch_req = 1'b1;
          next_done = 1'b0;
          next_valid = 1'b0;
          next_sig_err = 1'b0;
          next_cnt_err = 1'b0;
          next_res_err = 1'b0;
          next_nack_err = 1'b0;
          next_state = ccdd_pkg::CCDD_FETCH;
        end
      end
      ccdd_pkg::CCDD_FETCH:
      begin
        if (fetch_ack)
        begin
          next_ofs = (ofs == `CCDD_SIG_LEN - 8'h01) ? `CCDD_OFS_PART : ofs + 8'h01;
          if (fetch_nack)
          begin
            next_present[slot] = 1'b0;
            next_nack_err = 1'b1;
            next_fetch_req = 1'b0;
            next_state = ccdd_pkg::CCDD_IDLE;
            ev_err = 1'b1;
          end
          else if (ofs < `CCDD_SIG_LEN && fetch_data != sig_byte)
          begin
            next_present[slot] = 1'b1;
            next_sig_err = 1'b1;
            next_fetch_req = 1'b0;
            next_state = ccdd_pkg::CCDD_IDLE;
            ev_err = 1'b1;
          end
          else
          begin
            next_present[slot] = 1'b1;
            if (ofs == `CCDD_OFS_PINCNT + 8'h01 && word > `CCDD_PINCNT_MAX)
            begin
              next_cnt_err = 1'b1;
              ev_err = 1'b1;
            end
            if (ofs >= `CCDD_OFS_PINS && ofs < `CCDD_OFS_AUX33 && ofs[0])
            begin
              next_pad_valid = 1'b1;
              next_pad_index = pin;
              next_pad_word = honour(pin, word);
              if (!analog && word[`CCDD_PW_USED] && word[`CCDD_PW_RES_HI:`CCDD_PW_RES_LO] != 8'h00)
              begin
                next_res_err = 1'b1;
                ev_err = 1'b1;
              end
            end
            // Stop at the last descriptor byte; the free area is never fetched
            if (ofs == `CCDD_OFS_LAST)
            begin
              next_fetch_req = 1'b0;
              next_done = 1'b1;
              next_valid = !cnt_err && !res_err && !ev_err;
              next_state = ccdd_pkg::CCDD_IDLE;
              ev_done = 1'b1;
            end
          end
        end
      end
      default:
      begin
        next_state = ccdd_pkg::CCDD_IDLE;
        next_fetch_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ccdd_pkg::CCDD_IDLE;
      ofs <= 8'h00;
      slot <= 2'h0;
      present <= 4'h0;
      done <= 1'b0;
      valid <= 1'b0;
      sig_err <= 1'b0;
      cnt_err <= 1'b0;
      res_err <= 1'b0;
      nack_err <= 1'b0;
      fetch_req <= 1'b0;
      fetch_dev_addr <= `CCDD_EE_ADDR_LO;
      pad_valid <= 1'b0;
      pad_index <= 7'h00;
      pad_word <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      ofs <= next_ofs;
      slot <= next_slot;
      present <= next_present;
      done <= next_done;
      valid <= next_valid;
      sig_err <= next_sig_err;
      cnt_err <= next_cnt_err;
      res_err <= next_res_err;
      nack_err <= next_nack_err;
      fetch_req <= next_fetch_req;
      fetch_dev_addr <= next_fetch_dev_addr;
      pad_valid <= next_pad_valid;
      pad_index <= next_pad_index;
      pad_word <= next_pad_word;
    end
  end

  // Record bytes are a plain memory; contents are meaningful only once done is set
  always_ff @(posedge pclk)
  begin
    if (rec_we)
    begin
      rec[rec_idx] <= fetch_data;
    end
  end

  // Two-byte memory address, upper byte always zero in the decoded range
  assign fetch_mem_addr = {8'h00, ofs};

  // APB slave: no wait states, pready registered from the setup cycle
  always_comb
  begin
    next_pready = psel && !penable;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    next_irq_mask = irq_mask;
    next_irq_st = irq_st;
    if (wr_acc && paddr == `CCDD_REG_IRQ_STATUS)
    begin
      next_irq_st = irq_st & ~pwdata[1:0];
    end
    if (wr_acc && paddr == `CCDD_REG_IRQ_MASK)
    begin
      next_irq_mask = pwdata[1:0];
    end
    // Hardware events win over a same-cycle clear
    next_irq_st = next_irq_st | {ev_err, ev_done};
    next_irq = |(next_irq_st & next_irq_mask);
    if (psel && !penable)
    begin
      if (paddr[1:0] != 2'h0)
      begin
        next_pslverr = 1'b1;
      end
      else if (paddr >= `CCDD_REG_PIN0 && paddr <= `CCDD_REG_PINL)
      begin
        next_prdata = {16'h0000, honour(7'((paddr - `CCDD_REG_PIN0) >> 2),
          be16(`CCDD_OFS_PINS + 8'((paddr - `CCDD_REG_PIN0) >> 1)))};
      end
      else if (paddr >= `CCDD_REG_SERIAL0 && paddr <= `CCDD_REG_SERIAL2)
      begin
        next_prdata = {be16(`CCDD_OFS_SERIAL + 8'(paddr - `CCDD_REG_SERIAL0)),
          be16(`CCDD_OFS_SERIAL + 8'(paddr - `CCDD_REG_SERIAL0) + 8'h02)};
      end
      else if (paddr >= `CCDD_REG_PART0 && paddr <= `CCDD_REG_PART3)
      begin
        next_prdata = {be16(`CCDD_OFS_PART + 8'(paddr - `CCDD_REG_PART0)),
          be16(`CCDD_OFS_PART + 8'(paddr - `CCDD_REG_PART0) + 8'h02)};
      end
      else
      begin
        case (paddr)
          `CCDD_REG_CTRL: next_prdata = {29'h0000_0000, slot, 1'b0};
          `CCDD_REG_STATUS: next_prdata = {20'h0_0000, present, 1'b0, nack_err, res_err, cnt_err,
            sig_err, valid, done, state == ccdd_pkg::CCDD_FETCH};
          `CCDD_REG_IRQ_STATUS: next_prdata = {30'h0000_0000, irq_st};
          `CCDD_REG_IRQ_MASK: next_prdata = {30'h0000_0000, irq_mask};
          `CCDD_REG_PINCNT: next_prdata = {16'h0000, be16(`CCDD_OFS_PINCNT)};
          `CCDD_REG_AUX33: next_prdata = {16'h0000, be16(`CCDD_OFS_AUX33)};
          `CCDD_REG_IN5: next_prdata = {16'h0000, be16(`CCDD_OFS_IN5)};
          `CCDD_REG_SYS5: next_prdata = {16'h0000, be16(`CCDD_OFS_SYS5)};
          `CCDD_REG_SUPPLY: next_prdata = {15'h0000, be16(`CCDD_OFS_SUPPLY) != 16'h0000,
            be16(`CCDD_OFS_SUPPLY)};
          `CCDD_REG_SEQ: next_prdata = {18'h0_0000, 14'(dig(rec[`CCDD_OFS_SEQ - `CCDD_OFS_PART]) * 14'h03E8
            + dig(rec[`CCDD_OFS_SEQ - `CCDD_OFS_PART + 8'h01]) * 14'h0064
            + dig(rec[`CCDD_OFS_SEQ - `CCDD_OFS_PART + 8'h02]) * 14'h000A
            + dig(rec[`CCDD_OFS_SEQ - `CCDD_OFS_PART + 8'h03]))};
          `CCDD_REG_DATE: next_prdata = {9'h000, 7'(dig(rec[8'h14]) * 14'h000A + dig(rec[8'h15])),
            9'h000, 7'(dig(rec[8'h12]) * 14'h000A + dig(rec[8'h13]))};
          default: next_pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      irq_st <= 2'h0;
      irq_mask <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

endmodule : ccdd_decoder

/* File: bench/ccdd_properties.sv */
`timescale 1ns/10ps
module ccdd_properties #(
  parameter logic [6:0] ANALOG_FIRST = 7'h43,
  parameter logic [6:0] ANALOG_COUNT = 7'h07
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_req,
  input wire logic [6:0] fetch_dev_addr,
  input wire logic [15:0] fetch_mem_addr,
  input wire logic fetch_ack,
  input wire logic fetch_nack,
  input wire logic [7:0] fetch_data,
  input wire logic pad_valid,
  input wire logic [6:0] pad_index,
  input wire logic [15:0] pad_word
);
  logic [7:0] hi_byte;
  logic [15:0] exp_word;
  logic [6:0] exp_idx;
  logic [7:0] ofs;
  logic analog;
  logic sig_bad;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign ofs = fetch_mem_addr[7:0];
  // Any of the four signature bytes may be the one that differs
  assign sig_bad = (ofs == 8'h00 && fetch_data != 8'hAA) || (ofs == 8'h01 && fetch_data != 8'h55)
    || (ofs == 8'h02 && fetch_data != 8'h33) || (ofs == 8'h03 && fetch_data != 8'hEE);
  assign analog = pad_index >= ANALOG_FIRST && pad_index < ANALOG_FIRST + ANALOG_COUNT;
  // Mirror of the word the decoder should have built from the last two bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_byte <= 8'h00;
      exp_word <= 16'h0000;
      exp_idx <= 7'h00;
    end
    else if (fetch_req && fetch_ack && !fetch_nack)
    begin
      if (!ofs[0])
        hi_byte <= fetch_data;
      exp_word <= {hi_byte, fetch_data};
      exp_idx <= 7'((ofs - 8'h58) >> 1);
    end
  end
  sequence byte_done;
    fetch_req && fetch_ack && !fetch_nack;
  endsequence
  sequence pin_lsb_done;
    byte_done ##0 (ofs[0] && ofs >= 8'h59 && ofs <= 8'hEB);
  endsequence
  mem_addr_hi_a: assert property (fetch_req |-> fetch_mem_addr[15:8] == 8'h00)
    else $error("fetch memory address high byte not zero");
  dev_addr_range_a: assert property (fetch_req |-> fetch_dev_addr >= 7'h54 && fetch_dev_addr <= 7'h57)
    else $error("fetch device address out of range");
  free_area_a: assert property (fetch_req |-> ofs <= 8'hF3)
    else $error("fetch reached free area");
  part_after_sig_a: assert property (byte_done ##0 (ofs == 8'h03 && fetch_data == 8'hEE) ##1 fetch_req |-> ofs == 8'h3A)
    else $error("part number fetch did not follow signature");
  sig_abort_a: assert property (byte_done ##0 sig_bad |=> !fetch_req)
    else $error("decode went on after bad signature");
  fetch_order_a: assert property (byte_done ##0 (ofs >= 8'h3A && ofs < 8'hF3) ##1 fetch_req |-> ofs == $past(ofs) + 8'h01)
    else $error("record bytes fetched out of order");
  pad_after_pin_a: assert property (pin_lsb_done |=> pad_valid && pad_index == exp_idx)
    else $error("pin word not issued after its low byte");
  pad_word_a: assert property (pad_valid && !analog |-> pad_word == exp_word)
    else $error("pin word altered");
  analog_only_a: assert property (pad_valid && analog |-> pad_word == {exp_word[15], 15'h0000})
    else $error("analog pin word not reduced to use bit");
endmodule : ccdd_properties

bind ccdd_decoder ccdd_properties #(.ANALOG_FIRST(ANALOG_FIRST), .ANALOG_COUNT(ANALOG_COUNT)) i_ccdd_properties (
  .pclk, .presetn, .fetch_req, .fetch_dev_addr, .fetch_mem_addr, .fetch_ack, .fetch_nack, .fetch_data,
  .pad_valid, .pad_index, .pad_word);

/* File: bench/ccdd_eeprom_model.sv */
`timescale 1ns/10ps
module ccdd_eeprom_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_req,
  input wire logic [6:0] fetch_dev_addr,
  input wire logic [15:0] fetch_mem_addr,
  input wire logic [3:0] present,
  input wire logic [1:0] latency,
  output logic fetch_ack,
  output logic fetch_nack,
  output logic [7:0] fetch_data
);
  // Four board images of 256 bytes; the bench loads only those of slots 0 to 2
  logic [7:0] mem [0:1023];
  logic [1:0] wait_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_ack <= 1'b0;
      fetch_nack <= 1'b0;
      fetch_data <= 8'h00;
      wait_cnt <= 2'h0;
    end
    else if (fetch_req && !fetch_ack && wait_cnt >= latency)
    begin
      fetch_ack <= 1'b1;
      fetch_nack <= !present[fetch_dev_addr[1:0]] || fetch_dev_addr[6:2] != 5'h15;
      fetch_data <= mem[{fetch_dev_addr[1:0], fetch_mem_addr[7:0]}];
      wait_cnt <= 2'h0;
    end
    else
    begin
      fetch_ack <= 1'b0;
      fetch_nack <= 1'b0;
      // Data line is not held between bytes
      fetch_data <= ~fetch_data;
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule : ccdd_eeprom_model

/* File: bench/cape_descriptor_decoder_bench.sv */
`timescale 1ns/10ps
module cape_descriptor_decoder_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic fetch_req, fetch_ack, fetch_nack, pad_valid;
  logic [6:0] fetch_dev_addr, pad_index;
  logic [15:0] fetch_mem_addr, pad_word;
  logic [7:0] fetch_data;
  logic [3:0] present;
  logic [1:0] latency;
  logic [32:0] exp_q[$], mask_q[$];
  int error_cnt, comparisons, i;
  localparam logic [95:0] SERIAL = "1523ABCD0042";
  ccdd_decoder i_ccdd_decoder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fetch_req, .fetch_dev_addr, .fetch_mem_addr, .fetch_ack, .fetch_nack, .fetch_data, .pad_valid,
    .pad_index, .pad_word, .irq);
  ccdd_eeprom_model i_ccdd_eeprom_model (.pclk, .presetn, .fetch_req, .fetch_dev_addr, .fetch_mem_addr,
    .present, .latency, .fetch_ack, .fetch_nack, .fetch_data);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] w16(input int a);
    return {i_ccdd_eeprom_model.mem[a], i_ccdd_eeprom_model.mem[a + 1]};
  endfunction : w16
  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
      chk({pslverr, prdata} & mask_q.pop_front(), exp_q.pop_front());
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      error_cnt++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so no strobe is assigned twice in one step
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    exp_q.push_back(e & {1'b1, m});
    mask_q.push_back({1'b1, m});
    apb(1'b0, a, rnd());
  endtask : rd
  task automatic fill(input int s, input logic [7:0] sig3, input logic [15:0] cnt, input logic bad);
    int o;
    int b;
    b = s * 256;
    for (o = 0; o < 256; o++)
      i_ccdd_eeprom_model.mem[b + o] = 8'(rnd());
    for (o = 0; o < 12; o++)
      i_ccdd_eeprom_model.mem[b + 76 + o] = SERIAL[95 - 8 * o -: 8];
    // Reserved bits cleared so only the bad image trips the check
    for (o = 0; o < 74; o++)
    begin
      i_ccdd_eeprom_model.mem[b + 88 + 2 * o] &= 8'h80;
      i_ccdd_eeprom_model.mem[b + 89 + 2 * o] &= 8'h7F;
    end
    {i_ccdd_eeprom_model.mem[b], i_ccdd_eeprom_model.mem[b + 1]} = 16'hAA55;
    {i_ccdd_eeprom_model.mem[b + 2], i_ccdd_eeprom_model.mem[b + 3]} = {8'h33, sig3};
    {i_ccdd_eeprom_model.mem[b + 74], i_ccdd_eeprom_model.mem[b + 75]} = cnt;
    if (bad)
    begin
      {i_ccdd_eeprom_model.mem[b + 88], i_ccdd_eeprom_model.mem[b + 89]} = 16'h80C5;
      {i_ccdd_eeprom_model.mem[b + 242], i_ccdd_eeprom_model.mem[b + 243]} = 16'h0000;
    end
  endtask : fill
  task automatic run(input logic [1:0] s);
    int n;
    latency <= 2'(rnd());
    apb(1'b1, 12'h00C, 32'h0000_0003);
    apb(1'b1, 12'h008, 32'h0000_0003);
    apb(1'b1, 12'h000, {29'h0000_0000, s, 1'b1});
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    // Error events raise irq mid-decode, so also wait for the fetch to stop
    while (!(irq === 1'b1 && fetch_req === 1'b0) && n < 5000);
    if (n >= 5000)
    begin
      error_cnt++;
      final_report();
    end
    @(posedge pclk);
  endtask : run
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, latency} = '0;
    present = 4'h7;
    seed = 32'h0000_004F;
    error_cnt = 0;
    comparisons = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    fill(0, 8'hEE, 16'h005C, 1'b0);
    run(2'h0);
    rd(12'h004, 32'h0000_0106);
    rd(12'h008, 32'h0000_0001);
    rd(12'h010, 32'h0000_005C);
    for (i = 0; i < 3; i++)
      rd(12'h014 + 12'(4 * i), {16'h0000, w16(236 + 2 * i)});
    rd(12'h020, {15'h0000, |w16(242), w16(242)});
    for (i = 0; i < 4; i++)
      rd(12'h040 + 12'(4 * i), {w16(58 + 4 * i), w16(60 + 4 * i)});
    for (i = 0; i < 3; i++)
      rd(12'h024 + 12'(4 * i), SERIAL[95 - 32 * i -: 32]);
    rd(12'h030, 32'h0000_002A);
    rd(12'h034, 32'h0017_000F);
    for (i = 0; i < 74; i++)
      rd(12'h100 + 12'(4 * i), w16(88 + 2 * i) & (i >= 67 ? 16'h8000 : 16'hFFFF));
    apb(1'b1, 12'h00C, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    chk({32'h0000_0000, irq}, 33'h0_0000_0000);
    @(posedge pclk);
    apb(1'b1, 12'h008, 32'h0000_0001);
    rd(12'h008, 32'h0000_0000);
    fill(1, 8'hEE, 16'h005D, 1'b1);
    run(2'h1);
    rd(12'h004, 32'h0000_0032, 32'h0000_00FF);
    rd(12'h008, 32'h0000_0003);
    rd(12'h000, 32'h0000_0002);
    rd(12'h020, 32'h0000_0000);
    fill(2, 8'hEF, 16'h005C, 1'b0);
    run(2'h2);
    rd(12'h004, 32'h0000_0008, 32'h0000_007D);
    run(2'h3);
    rd(12'h004, 32'h0000_0040, 32'h0000_007D);
    rd(12'h0FC, 33'h1_0000_0000);
    rd(12'h002, 33'h1_0000_0000);
    final_report();
  end
endmodule : cape_descriptor_decoder_bench
